// >>> rtl/ppgv_pkg.sv
// ppgv_pkg: constants shared by the pattern generator, checker, lfsr and fifo
// assumes: one clock domain, synchronous active-high resets
`default_nettype none
package ppgv_pkg;
  // pattern select codes on pattern_sel
  localparam logic [2:0] MODE_PRBS7 = 3'h0;
  localparam logic [2:0] MODE_PRBS8 = 3'h1;
  localparam logic [2:0] MODE_PRBS10 = 3'h2;
  localparam logic [2:0] MODE_PRBS23 = 3'h3;
  localparam logic [2:0] MODE_HIFREQ = 3'h4;
  localparam logic [2:0] MODE_LOFREQ = 3'h5;
  // polynomial orders and second taps
  localparam logic [4:0] ORD_P7 = 5'h07;
  localparam logic [4:0] TAP_P7 = 5'h06;
  localparam logic [4:0] ORD_P8 = 5'h08;
  localparam logic [4:0] TAP_P8 = 5'h07;
  localparam logic [4:0] ORD_P10 = 5'h0a;
  localparam logic [4:0] TAP_P10 = 5'h07;
  localparam logic [4:0] ORD_P23 = 5'h17;
  localparam logic [4:0] TAP_P23 = 5'h12;
  // word alignment patterns
  localparam logic [15:0] ALIGN_P7 = 16'h3040;
  localparam logic [15:0] ALIGN_P8 = 16'hff5a;
  localparam logic [15:0] ALIGN_P10 = 16'h03ff;
  localparam logic [15:0] ALIGN_P23 = 16'hffff;
  // fixed-frequency words
  localparam logic [9:0] HF_WORD = 10'h2aa;
  localparam logic [9:0] LF_WORD = 10'h3e0;
  // widths
  localparam int LFSR_LEN = 23;
  localparam int WORD_MAX = 10;
  localparam logic [3:0] NBITS_NARROW = 4'h8;
  localparam logic [3:0] NBITS_WIDE = 4'ha;
  localparam logic [9:0] MASK_NARROW = 10'h0ff;
  localparam logic [9:0] MASK_WIDE = 10'h3ff;
  localparam logic [22:0] LFSR_SEED = 23'h7fffff;
  // pattern cycle lengths, 2**(order-1) bits, in whole words
  localparam int CYC_BITS_P7 = 2 ** (7 - 1);
  localparam int CYC_BITS_P8 = 2 ** (8 - 1);
  localparam int CYC_BITS_P10 = 2 ** (10 - 1);
  localparam int CYC_BITS_P23 = 2 ** (23 - 1);
  localparam int CYC_WORDS_P7 = (CYC_BITS_P7 + 7) / 8;
  localparam int CYC_WORDS_P8 = (CYC_BITS_P8 + 7) / 8;
  localparam int CYC_WORDS_P10 = (CYC_BITS_P10 + 9) / 10;
  localparam int CYC_WORDS_P23 = (CYC_BITS_P23 + 7) / 8;
  localparam int CNT_W = 24;
  // error flag minimum hold in clock cycles
  localparam logic [1:0] ERR_MIN_CYCLES = 2'h3;
  typedef enum logic [1:0] {CHK_IDLE, CHK_WARM, CHK_COUNT, CHK_DONE} ppgv_chk_state_t;
endpackage
`default_nettype wire

// >>> rtl/ppgv_lfsr_step.sv
// ppgv_lfsr_step: advances a fibonacci lfsr by up to one word of bits
// assumes: purely combinational; bit 0 of a word is the first bit on the line
`default_nettype none
module ppgv_lfsr_step (
  input wire logic [22:0] state,
  input wire logic [4:0] tap_a,
  input wire logic [4:0] tap_b,
  input wire logic [3:0] nbits,
  input wire logic [9:0] data_in,
  input wire logic use_data,
  output logic [9:0] exp_word,
  output logic [22:0] next_state
);
  always_comb begin
    logic [22:0] s;
    logic fb;
    logic b;
    s = state;
    fb = 1'b0;
    b = 1'b0;
    exp_word = 10'h000;
    for (int i = 0; i < 10; i++) begin
      if (4'(i) < nbits) begin
        fb = s[tap_a - 5'h01] ^ s[tap_b - 5'h01];
        exp_word[i] = fb;
        // checker reloads from the line, generator from itself
        b = use_data ? data_in[i] : fb;
        s = {s[21:0], b};
      end
    end
    next_state = s;
  end
endmodule
`default_nettype wire

// >>> rtl/ppgv_fifo.sv
// ppgv_fifo: small synchronous fifo with valid/ready on both sides
// assumes: DEPTH is a power of two; ce low freezes all state
`default_nettype none
module ppgv_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wptr;
  logic [AW:0] rptr;
  logic full;
  logic empty;
  logic push;
  logic pop;

  assign empty = (wptr == rptr);
  assign full = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
  assign in_ready = ~full;
  assign out_valid = ~empty;
  assign out_data = mem[rptr[AW-1:0]];
  assign push = ce & in_valid & ~full;
  assign pop = ce & out_ready & ~empty;

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wptr <= '0;
      rptr <= '0;
    end else begin
      if (push) begin
        wptr <= wptr + 1'b1;
      end
      if (pop) begin
        rptr <= rptr + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> rtl/ppgv_top.sv
// ppgv_top: per-channel self-test pattern generator and pseudo-random checker
// assumes: all inputs come from logic on core_clk; the serializer drains ser_data
// and the word aligner supplies aln_data with aln_locked once the boundary is found
//
// Overview of operation
// R01: generator words feed the serializer input directly; here they pass through u_tx_fifo first
// R02: checker examines words from word aligner output
// R03: pattern restarts after 2**(order-1) bits
// R04: order-7 uses x7+x6+1, 8-bit, align 3040
// R05: order-8 uses x8+x7+1, 8-bit, align ff5a
// R06: order-23 uses x23+x18+1, 8-bit, align ffff
// R07: width selects 8/10 bits; order-10, low-frequency 10-bit
// R08: fixed-frequency patterns have no checker or status
// R09: user may loop serial output back to checker
// R10: done rises after one cycle, holds until reset
// R11: error flag held three cycles minimum after done
// R12: error flag clears after one error-free sequence
// R13: transmit and receive resets act independently
// R14: self-test works only in basic mode
// R15: one generator word every clock, no gaps; here the generator pauses while u_tx_fifo is full
`default_nettype none
module ppgv_top #(
  parameter int FIFO_DEPTH = 8,
  parameter int P23_CYCLE_WORDS = ppgv_pkg::CYC_WORDS_P23
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic tx_digital_reset,
  input wire logic rx_digital_reset,
  input wire logic basic_mode,
  input wire logic width_10b,
  input wire logic [2:0] pattern_sel,
  output logic mode_invalid,
  output logic [15:0] align_pattern,
  output logic [9:0] ser_data,
  output logic ser_valid,
  input wire logic ser_ready,
  input wire logic [9:0] aln_data,
  input wire logic aln_valid,
  input wire logic aln_locked,
  output logic chk_done,
  output logic chk_err,
  output logic [15:0] err_word_count
);
  // ---------------- mode decode ----------------
  logic tx_rst;
  logic rx_rst;
  logic is_prbs;
  logic legal;
  logic [4:0] tap_a;
  logic [4:0] tap_b;
  logic [3:0] nbits;
  logic [9:0] word_mask;
  logic [15:0] next_align;
  logic [ppgv_pkg::CNT_W-1:0] cycle_words;
  logic [ppgv_pkg::CNT_W-1:0] warm_words;

  assign tx_rst = srst | tx_digital_reset; // R13
  assign rx_rst = srst | rx_digital_reset; // R13
  assign nbits = width_10b ? ppgv_pkg::NBITS_WIDE : ppgv_pkg::NBITS_NARROW; // R07
  assign word_mask = width_10b ? ppgv_pkg::MASK_WIDE : ppgv_pkg::MASK_NARROW;

  always_comb begin
    is_prbs = 1'b1;
    legal = 1'b0;
    tap_a = ppgv_pkg::ORD_P7;
    tap_b = ppgv_pkg::TAP_P7;
    next_align = 16'h0000;
    cycle_words = ppgv_pkg::CNT_W'(ppgv_pkg::CYC_WORDS_P7);
    case (pattern_sel)
      ppgv_pkg::MODE_PRBS7: begin
        legal = ~width_10b; // R04
        next_align = ppgv_pkg::ALIGN_P7; // R04
      end
      ppgv_pkg::MODE_PRBS8: begin
        legal = ~width_10b; // R05
        tap_a = ppgv_pkg::ORD_P8; // R05
        tap_b = ppgv_pkg::TAP_P8;
        next_align = ppgv_pkg::ALIGN_P8;
        cycle_words = ppgv_pkg::CNT_W'(ppgv_pkg::CYC_WORDS_P8);
      end
      ppgv_pkg::MODE_PRBS10: begin
        legal = width_10b; // R07
        tap_a = ppgv_pkg::ORD_P10; // R07
        tap_b = ppgv_pkg::TAP_P10;
        next_align = ppgv_pkg::ALIGN_P10;
        cycle_words = ppgv_pkg::CNT_W'(ppgv_pkg::CYC_WORDS_P10);
      end
      ppgv_pkg::MODE_PRBS23: begin
        legal = ~width_10b; // R06
        tap_a = ppgv_pkg::ORD_P23; // R06
        tap_b = ppgv_pkg::TAP_P23;
        next_align = ppgv_pkg::ALIGN_P23;
        cycle_words = ppgv_pkg::CNT_W'(P23_CYCLE_WORDS);
      end
      ppgv_pkg::MODE_HIFREQ: begin
        is_prbs = 1'b0; // R08
        legal = 1'b1;
      end
      ppgv_pkg::MODE_LOFREQ: begin
        is_prbs = 1'b0; // R08
        legal = width_10b; // R07
      end
      default: begin
        is_prbs = 1'b0;
        legal = 1'b0;
      end
    endcase
  end

  // words needed to fill the checker shift register before comparing
  assign warm_words = (tap_a > 5'h0a) ? ppgv_pkg::CNT_W'(3) : ppgv_pkg::CNT_W'(1);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      mode_invalid <= 1'b0;
    end else if (ce) begin
      mode_invalid <= basic_mode & ~legal; // R07 R14
    end
  end

  // aligner pattern only for a legal mode in basic mode
  always_ff @(posedge core_clk) begin
    if (srst) begin
      align_pattern <= 16'h0000;
    end else if (ce) begin
      align_pattern <= (basic_mode & legal) ? next_align : 16'h0000; // R04 R05 R06 R07
    end
  end

  // ---------------- generator ----------------
  logic gen_active;
  logic [22:0] gen_state;
  logic [22:0] gen_next;
  logic [9:0] gen_prbs;
  logic [9:0] gen_word;
  logic fifo_in_ready;
  logic gen_push;

  assign gen_active = basic_mode & legal; // R14

  ppgv_lfsr_step u_gen_step (
    .state(gen_state),
    .tap_a(tap_a),
    .tap_b(tap_b),
    .nbits(nbits),
    .data_in(10'h000),
    .use_data(1'b0),
    .exp_word(gen_prbs),
    .next_state(gen_next)
  );

  always_comb begin
    if (is_prbs) begin
      gen_word = gen_prbs & word_mask; // R03
    end else if (pattern_sel == ppgv_pkg::MODE_HIFREQ) begin
      gen_word = ppgv_pkg::HF_WORD & word_mask; // R08
    end else begin
      gen_word = ppgv_pkg::LF_WORD; // R08
    end
  end

  // one word per cycle unless the serializer stalls the fifo
  assign gen_push = gen_active & fifo_in_ready; // R15

  always_ff @(posedge core_clk) begin
    if (tx_rst) begin
      gen_state <= ppgv_pkg::LFSR_SEED; // R13
    end else if (ce && gen_push && is_prbs) begin
      gen_state <= gen_next; // R03
    end
  end

  ppgv_fifo #(
    .WIDTH(ppgv_pkg::WORD_MAX),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .core_clk(core_clk),
    .rst(tx_rst),
    .ce(ce),
    .in_valid(gen_active),
    .in_ready(fifo_in_ready),
    .in_data(gen_word),
    .out_valid(ser_valid), // R01
    .out_ready(ser_ready),
    .out_data(ser_data) // R01
  );

  // ---------------- checker ----------------
  ppgv_pkg::ppgv_chk_state_t chk_st;
  ppgv_pkg::ppgv_chk_state_t next_chk_st;
  logic chk_active;
  logic take;
  logic [22:0] chk_state;
  logic [22:0] chk_next;
  logic [9:0] chk_exp;
  logic word_err;
  logic [ppgv_pkg::CNT_W-1:0] word_cnt;
  logic [ppgv_pkg::CNT_W-1:0] clean_cnt;
  logic [1:0] hold_cnt;
  logic err_hit;

  // checker only runs for pseudo-random patterns in basic mode
  assign chk_active = basic_mode & legal & is_prbs; // R08 R14
  assign take = ce & chk_active & aln_valid; // R02

  ppgv_lfsr_step u_chk_step (
    .state(chk_state),
    .tap_a(tap_a),
    .tap_b(tap_b),
    .nbits(nbits),
    .data_in(aln_data),
    .use_data(1'b1),
    .exp_word(chk_exp),
    .next_state(chk_next)
  );

  assign word_err = |((chk_exp ^ aln_data) & word_mask); // R02

  // self-synchronising: the shift register always reloads from the line
  always_ff @(posedge core_clk) begin
    if (rx_rst) begin
      chk_state <= ppgv_pkg::LFSR_SEED; // R13
    end else if (take) begin
      chk_state <= chk_next;
    end
  end

  always_comb begin
    next_chk_st = chk_st;
    case (chk_st)
      ppgv_pkg::CHK_IDLE: begin
        if (take && aln_locked) begin
          next_chk_st = ppgv_pkg::CHK_WARM; // R10
        end
      end
      ppgv_pkg::CHK_WARM: begin
        if (!aln_locked) begin
          next_chk_st = ppgv_pkg::CHK_IDLE;
        end else if (take && word_cnt + 1'b1 >= warm_words) begin
          next_chk_st = ppgv_pkg::CHK_COUNT;
        end
      end
      ppgv_pkg::CHK_COUNT: begin
        if (!aln_locked) begin
          next_chk_st = ppgv_pkg::CHK_IDLE;
        end else if (take && word_cnt + 1'b1 >= cycle_words) begin
          next_chk_st = ppgv_pkg::CHK_DONE; // R10
        end
      end
      ppgv_pkg::CHK_DONE: begin
        next_chk_st = ppgv_pkg::CHK_DONE; // R10
      end
      default: begin
        next_chk_st = ppgv_pkg::CHK_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rx_rst) begin
      chk_st <= ppgv_pkg::CHK_IDLE; // R13
    end else if (ce) begin
      chk_st <= next_chk_st;
    end
  end

  // word counter restarts on each state change
  always_ff @(posedge core_clk) begin
    if (rx_rst) begin
      word_cnt <= '0;
    end else if (ce) begin
      if (next_chk_st != chk_st) begin
        word_cnt <= '0;
      end else if (take && chk_st != ppgv_pkg::CHK_DONE) begin
        word_cnt <= word_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rx_rst) begin
      chk_done <= 1'b0;
    end else if (ce && next_chk_st == ppgv_pkg::CHK_DONE) begin
      chk_done <= 1'b1; // R10
    end
  end

  // an error counts only once done has risen
  assign err_hit = chk_done & take & word_err; // R11

  // minimum high time, reloaded by every new error
  always_ff @(posedge core_clk) begin
    if (rx_rst) begin
      hold_cnt <= 2'h0;
    end else if (ce) begin
      if (err_hit) begin
        hold_cnt <= ppgv_pkg::ERR_MIN_CYCLES - 2'h1; // R11
      end else if (hold_cnt != 2'h0) begin
        hold_cnt <= hold_cnt - 2'h1; // R11
      end
    end
  end

  // clean words since the last error, saturating at one cycle
  always_ff @(posedge core_clk) begin
    if (rx_rst) begin
      clean_cnt <= '0;
    end else if (ce) begin
      if (err_hit) begin
        clean_cnt <= '0;
      end else if (take && clean_cnt < cycle_words) begin
        clean_cnt <= clean_cnt + 1'b1; // R12
      end
    end
  end

  // error flag: set wins, clears after hold and a clean sequence
  always_ff @(posedge core_clk) begin
    if (rx_rst) begin
      chk_err <= 1'b0;
    end else if (ce) begin
      if (err_hit) begin
        chk_err <= 1'b1; // R11
      end else if (hold_cnt == 2'h0 && clean_cnt >= cycle_words) begin
        chk_err <= 1'b0; // R12
      end
    end
  end

  // saturating count of words received in error after done
  always_ff @(posedge core_clk) begin
    if (rx_rst) begin
      err_word_count <= 16'h0000;
    end else if (ce && err_hit && err_word_count != 16'hffff) begin
      err_word_count <= err_word_count + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// >>> dv/ppgv_top_chk.sv
// ppgv_top_chk: concurrent checks on the ports of ppgv_top
// assumes: bound into ppgv_top, one clock core_clk, srst synchronous
`default_nettype none
module ppgv_top_chk #(
  parameter int FIFO_DEPTH = 8,
  parameter int P23_CYCLE_WORDS = ppgv_pkg::CYC_WORDS_P23
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic tx_digital_reset,
  input wire logic rx_digital_reset,
  input wire logic basic_mode,
  input wire logic width_10b,
  input wire logic [2:0] pattern_sel,
  input wire logic mode_invalid,
  input wire logic [15:0] align_pattern,
  input wire logic ser_valid,
  input wire logic ser_ready,
  input wire logic chk_done,
  input wire logic chk_err,
  input wire logic [15:0] err_word_count
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);
  property p_done_sticky;
    disable iff (srst || rx_digital_reset) chk_done |=> chk_done;
  endproperty
  a_done_sticky: assert property (p_done_sticky) else $error("done dropped");
  property p_err_hold;
    disable iff (srst || rx_digital_reset) $rose(chk_err) |-> chk_err [*3];
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error flag too short");
  property p_err_needs_done;
    chk_err |-> chk_done;
  endproperty
  a_err_needs_done: assert property (p_err_needs_done) else $error("error before done");
  property p_rx_rst;
    rx_digital_reset |=> !chk_done && !chk_err && err_word_count == 16'h0000;
  endproperty
  a_rx_rst: assert property (p_rx_rst) else $error("checker not reset");
  property p_tx_rst;
    tx_digital_reset |=> !ser_valid;
  endproperty
  a_tx_rst: assert property (p_tx_rst) else $error("generator not reset");
  property p_align_p7;
    ce && basic_mode && !width_10b && pattern_sel == ppgv_pkg::MODE_PRBS7 |=> align_pattern == ppgv_pkg::ALIGN_P7;
  endproperty
  a_align_p7: assert property (p_align_p7) else $error("wrong align pattern");
  property p_lf_narrow;
    ce && basic_mode && !width_10b && pattern_sel == ppgv_pkg::MODE_LOFREQ |=> mode_invalid;
  endproperty
  a_lf_narrow: assert property (p_lf_narrow) else $error("narrow low-freq accepted");
  property p_gapless;
    ce && ser_valid && ser_ready && basic_mode && !mode_invalid && !tx_digital_reset && $stable(pattern_sel)
      |=> ser_valid;
  endproperty
  a_gapless: assert property (p_gapless) else $error("gap in word stream");
  property p_fixed_no_done;
    disable iff (srst || rx_digital_reset)
      pattern_sel == ppgv_pkg::MODE_HIFREQ && $past(pattern_sel) == ppgv_pkg::MODE_HIFREQ && !chk_done |=> !chk_done;
  endproperty
  a_fixed_no_done: assert property (p_fixed_no_done) else $error("done on fixed pattern");
  c_done: cover property ($rose(chk_done));
  c_err: cover property ($rose(chk_err));
  c_stall: cover property (ser_valid && !ser_ready);
endmodule
bind ppgv_top ppgv_top_chk #(.FIFO_DEPTH(FIFO_DEPTH), .P23_CYCLE_WORDS(P23_CYCLE_WORDS)) u_chk (.core_clk, .srst,
  .ce, .tx_digital_reset, .rx_digital_reset, .basic_mode, .width_10b, .pattern_sel, .mode_invalid,
  .align_pattern, .ser_valid, .ser_ready, .chk_done, .chk_err, .err_word_count);
`default_nettype wire

// >>> dv/ppgv_loop_model.sv
// ppgv_loop_model: serial loopback partner, serializer words back to the aligner
// assumes: same core_clk; stall and inject come from the bench
`default_nettype none
module ppgv_loop_model (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic stall,
  input wire logic inject,
  input wire logic [9:0] ser_data,
  input wire logic ser_valid,
  output logic ser_ready,
  output logic [9:0] aln_data,
  output logic aln_valid,
  output logic aln_locked
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge core_clk) begin
    ser_ready <= !stall;
    if (srst) begin
      aln_valid <= 1'b0;
      aln_locked <= 1'b0;
      aln_data <= 10'h000;
    end else if (ce && ser_valid && ser_ready) begin
      aln_data <= ser_data ^ {9'h000, inject};
      aln_valid <= 1'b1;
      aln_locked <= 1'b1;
    end else begin
      // no stale word between strobes
      aln_data <= ~aln_data;
      aln_valid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> dv/test_ppgv_top.sv
// test_ppgv_top: self-checking bench for ppgv_top with a loopback partner
// assumes: checker bound in by its own file
`default_nettype none
module test_ppgv_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [2:0] sel; logic w10; logic inv; logic [15:0] align;
    logic [4:0] ord; logic [4:0] tap; logic [9:0] word; logic [7:0] ndone;
  } ppgv_row_t;
  logic core_clk, srst, ce, tx_digital_reset, rx_digital_reset, basic_mode, width_10b, stall, inject;
  logic [2:0] pattern_sel;
  logic mode_invalid, ser_valid, ser_ready, aln_valid, aln_locked, chk_done, chk_err;
  logic [15:0] align_pattern, err_word_count;
  logic [9:0] ser_data, aln_data;
  int n_mismatch = 0;
  int samples_checked = 0;
  ppgv_row_t rows [11] = '{
    '{3'h0, 1'b0, 1'b0, 16'h3040, 5'h07, 5'h06, 10'h000, 8'h0a},
    '{3'h1, 1'b0, 1'b0, 16'hff5a, 5'h08, 5'h07, 10'h000, 8'h12},
    '{3'h2, 1'b1, 1'b0, 16'h03ff, 5'h0a, 5'h07, 10'h000, 8'h36},
    '{3'h3, 1'b0, 1'b0, 16'hffff, 5'h17, 5'h12, 10'h000, 8'h14},
    '{3'h4, 1'b0, 1'b0, 16'h0000, 5'h00, 5'h00, 10'h0aa, 8'h00},
    '{3'h4, 1'b1, 1'b0, 16'h0000, 5'h00, 5'h00, 10'h2aa, 8'h00},
    '{3'h5, 1'b1, 1'b0, 16'h0000, 5'h00, 5'h00, 10'h3e0, 8'h00},
    '{3'h5, 1'b0, 1'b1, 16'h0000, 5'h00, 5'h00, 10'h000, 8'h00},
    '{3'h2, 1'b0, 1'b1, 16'h0000, 5'h00, 5'h00, 10'h000, 8'h00},
    '{3'h0, 1'b1, 1'b1, 16'h0000, 5'h00, 5'h00, 10'h000, 8'h00},
    '{3'h6, 1'b1, 1'b1, 16'h0000, 5'h00, 5'h00, 10'h000, 8'h00}
  };
  ppgv_top #(.FIFO_DEPTH(8), .P23_CYCLE_WORDS(16)) dut (.core_clk, .srst, .ce, .tx_digital_reset,
    .rx_digital_reset, .basic_mode, .width_10b, .pattern_sel, .mode_invalid, .align_pattern, .ser_data,
    .ser_valid, .ser_ready, .aln_data, .aln_valid, .aln_locked, .chk_done, .chk_err, .err_word_count);
  ppgv_loop_model u_loop (.core_clk, .srst, .ce, .stall, .inject, .ser_data, .ser_valid, .ser_ready,
    .aln_data, .aln_valid, .aln_locked);
  task automatic wrap_up;
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // first word from an all-ones seed, first line bit in bit 0
  function automatic logic [9:0] first_word(input ppgv_row_t r);
    logic [22:0] s;
    logic [9:0] w;
    s = 23'h7fffff;
    w = 10'h000;
    for (int k = 0; k < (r.w10 ? 10 : 8); k++) begin
      w[k] = s[r.ord-1] ^ s[r.tap-1];
      s = {s[21:0], w[k]};
    end
    return w;
  endfunction
  task automatic side_rst(input logic tx, input logic rx);
    @(posedge core_clk);
    tx_digital_reset <= tx;
    rx_digital_reset <= rx;
    @(posedge core_clk);
    tx_digital_reset <= 1'b0;
    rx_digital_reset <= 1'b0;
  endtask
  task automatic do_row(input ppgv_row_t r);
    int n;
    int i;
    @(posedge core_clk);
    stall <= 1'b1;
    basic_mode <= 1'b1;
    pattern_sel <= r.sel;
    width_10b <= r.w10;
    side_rst(1'b1, 1'b1);
    repeat (12) @(posedge core_clk);
    @(negedge core_clk);
    chk(16'(mode_invalid), 16'(r.inv));
    chk(16'(ser_valid), 16'(!r.inv));
    if (!r.inv) begin
      chk(align_pattern, r.align);
      chk(16'(ser_data), 16'(r.ord == 5'h00 ? r.word : first_word(r)));
      @(posedge core_clk);
      stall <= 1'b0;
      n = 0;
      for (i = 0; i < 400 && !chk_done; i++) begin
        @(negedge core_clk);
        if (!chk_done && aln_valid) n++;
      end
      chk(16'(chk_done ? n : 0), 16'(r.ndone));
      if (r.ndone != 8'h00 && !chk_done) wrap_up();
    end
  endtask
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    int i;
    int n;
    {srst, ce, stall} = 3'h7;
    {tx_digital_reset, rx_digital_reset, basic_mode, width_10b, inject, pattern_sel} = 8'h20;
    repeat (15) @(posedge core_clk);
    @(negedge core_clk);
    chk({ser_valid, chk_done, mode_invalid}, 16'h0000);
    chk(align_pattern, 16'h0000);
    @(posedge core_clk);
    srst <= 1'b0;
    foreach (rows[k]) do_row(rows[k]);
    do_row(rows[0]);
    n = 0;
    repeat (20) begin
      @(negedge core_clk);
      if (ser_valid && ser_ready) n++;
    end
    chk(16'(n), 16'h0014);
    @(posedge core_clk);
    inject <= 1'b1;
    @(posedge core_clk);
    inject <= 1'b0;
    for (i = 0; i < 20 && !chk_err; i++) @(negedge core_clk);
    chk(16'(chk_err), 16'h0001);
    if (!chk_err) wrap_up();
    chk(16'(err_word_count == 16'h0000), 16'h0000);
    for (i = 0; i < 200 && chk_err; i++) @(negedge core_clk);
    chk(16'(chk_err), 16'h0000);
    chk(16'(chk_done), 16'h0001);
    side_rst(1'b0, 1'b1);
    @(negedge core_clk);
    chk({chk_done, chk_err, ser_valid}, 16'h0001);
    chk(err_word_count, 16'h0000);
    @(posedge core_clk);
    ce <= 1'b0;
    repeat (20) @(posedge core_clk);
    @(negedge core_clk);
    chk(16'(chk_done), 16'h0000);
    @(posedge core_clk);
    ce <= 1'b1;
    for (i = 0; i < 40 && !chk_done; i++) @(negedge core_clk);
    chk(16'(chk_done), 16'h0001);
    @(posedge core_clk);
    basic_mode <= 1'b0;
    side_rst(1'b1, 1'b1);
    repeat (12) @(posedge core_clk);
    @(negedge core_clk);
    chk({ser_valid, mode_invalid}, 16'h0000);
    wrap_up();
  end
endmodule
`default_nettype wire
